/* logic/lcd_status_irq_cfg.svh */
// constants for the panel controller status, interrupt and register block
// assumes a 200 MHz core clock and a 32-bit word-addressed register port
//
// Summary of operation
// - each interrupt source owns one status bit
// - sticky status set by hardware, software clears
// - read-only flags ignore software writes
// - control register mask bits suppress some sources
// - settings versus dma buffer size mismatch flags error
// - line comparator raises line interrupt on match
// - line interrupt is a level for the line
// - both interrupt outputs active low, same behaviour
// - line interrupt wired to a dma request
// - any logical channel 0-15 may use it
// - subpanel fetches only first or last lines
// - other lines take default pixel, no fetches
// - dma may gate its clocks during default fill
// - eight registers: control, timing a-c, status, subpanel, line match, scan
// - fixed word offsets 0x00 to 0x1c
// - minimum spacing between palette fetch requests
// - spacing applies only to palette loading
// - line status cleared by software or line end
// - mask bit 0 blocks, 1 passes
// - load mode 00 both, 01 palette, 10 data
`ifndef LCD_STATUS_IRQ_CFG_SVH
`define LCD_STATUS_IRQ_CFG_SVH

`define OFS_CONTROL    8'h00
`define OFS_TIMING_A   8'h04
`define OFS_TIMING_B   8'h08
`define OFS_TIMING_C   8'h0c
`define OFS_STATUS     8'h10
`define OFS_SUBPANEL   8'h14
`define OFS_LINE_MATCH 8'h18
`define OFS_SCAN       8'h1c

`define CTL_ON          0
`define CTL_MONO        1
`define CTL_VSYNC_EN    2
`define CTL_DONE_EN     3
`define CTL_LOAD_EN     4
`define CTL_LINE_NIRQ   5
`define CTL_LINE_EN     6
`define CTL_CLR_SEL     10
`define CTL_SPACING_LO  12
`define CTL_LOAD_SEL_LO 20
`define CTL_WIDTH       25
`define CTL_RESV        32'hfe00_0000

`define ST_DONE     0
`define ST_VSYNC    1
`define ST_LINE     2
`define ST_LOADED   3
`define ST_SYNC_ERR 4
`define ST_UNDERRUN 5

`define SUB_EN      31
`define SUB_TOP     30
`define SUB_LINE_LO 16

`define LOAD_BOTH    2'h0
`define LOAD_PALETTE 2'h1
`define LOAD_DATA    2'h2

`define RST_WORD    32'h0000_0000
`define PAL_WORDS   16

`endif

/* logic/lcd_status_irq_pkg.sv */
// types shared by both ends of the panel controller link
// assumes lcd_status_irq_cfg.svh is on the include path
`default_nettype none
package lcd_status_irq_pkg;
    typedef enum {
        PAL_IDLE,
        PAL_REQ,
        PAL_GAP,
        PAL_DATA
    } pal_state_t;
endpackage : lcd_status_irq_pkg
`default_nettype wire

/* logic/lcd_link_if.sv */
// link between the panel controller and the dma / interrupt controller
// assumes both ends share core_clk
`default_nettype none
interface lcd_link_if;
    logic        fetch_req;
    logic        fetch_palette;
    logic        fetch_ack;
    logic        default_fill;
    logic [31:0] buf_words;
    logic        irq_n;
    logic        line_irq_n;
    modport device (output fetch_req, output fetch_palette,
                    output default_fill, output irq_n, output line_irq_n,
                    input fetch_ack, input buf_words);
    modport system (input fetch_req, input fetch_palette,
                    input default_fill, input irq_n, input line_irq_n,
                    output fetch_ack, output buf_words);
endinterface : lcd_link_if
`default_nettype wire

/* logic/lcd_status_irq_regs.sv */
// panel controller register bank, status bits, interrupts, line
// comparator, palette spacing and subpanel fetch selection
// assumes line_start and frame_start pulses come from the sync timer
`include "lcd_status_irq_cfg.svh"
`default_nettype none
module lcd_status_irq_regs
    import lcd_status_irq_pkg::*;
#(
    parameter int LINE_W    = 10,
    parameter int PAL_WORDS = `PAL_WORDS
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        line_start,
    input  wire logic        frame_start,
    input  wire logic        fifo_underrun,
    output logic             use_default_pixel,
    output logic      [15:0] default_pixel_value,
    output logic             controller_on,
    lcd_link_if.device       link
);
    initial begin
        if (LINE_W < 1 || LINE_W > 16 || PAL_WORDS < 1 || PAL_WORDS > 256)
            $error("lcd_status_irq_regs: unsupported parameters");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0]       ctl;
        logic [31:0]       tim_a;
        logic [31:0]       tim_b;
        logic [31:0]       tim_c;
        logic [5:0]        sts;
        logic [31:0]       sub;
        logic [LINE_W-1:0] match;
        logic [LINE_W-1:0] line;
        logic              active;
        pal_state_t        pal;
        logic [7:0]        pal_cnt;
        logic [7:0]        gap;
        logic              req;
        logic              req_pal;
        logic              dflt;
        logic [31:0]       rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ==========================================================
    // helpers
    function automatic logic [31:0] expected_words(input logic [31:0] a,
                                                   input logic [31:0] b,
                                                   input logic [31:0] c);
        logic [47:0] bits;
        bits = 48'({a[9:0], 1'b0} >> 1) + 48'h1;
        bits = bits * (48'(b[9:0]) + 48'h1);
        bits = bits << c[2:0];
        return bits[35:4];
    endfunction : expected_words

    // lines fetched through dma: first or last group when subpanel is on
    function automatic logic line_fetched(input logic [31:0] sub,
                                          input logic [LINE_W-1:0] ln);
        logic below;
        below = ln < sub[`SUB_LINE_LO +: LINE_W];
        if (!sub[`SUB_EN])
            return 1'b1;
        return sub[`SUB_TOP] ? below : !below;
    endfunction : line_fetched

    logic [1:0] palette_load_select;
    logic       matched;
    logic [5:0] sts_set;
    logic [5:0] src_en;

    assign palette_load_select = st_r.ctl[`CTL_LOAD_SEL_LO +: 2];
    assign matched = st_r.active && (st_r.line == st_r.match);

    // ==========================================================
    // next state
    always_comb begin
        st_nxt       = st_r;
        sts_set      = '0;
        st_nxt.rdata = '0;

        // frame and line tracking
        if (frame_start) begin
            st_nxt.line = '0;
            if (st_r.active && !st_r.ctl[`CTL_ON])
                sts_set[`ST_DONE] = 1'b1;
            st_nxt.active = st_r.ctl[`CTL_ON];
            if (st_r.ctl[`CTL_ON]) begin
                sts_set[`ST_VSYNC] = 1'b1;
                if (expected_words(st_r.tim_a, st_r.tim_b, st_r.tim_c)
                        != link.buf_words)
                    sts_set[`ST_SYNC_ERR] = 1'b1;
            end
        end else if (line_start && st_r.active) begin
            st_nxt.line = st_r.line + 1'b1;
        end
        // the matched line ends at this line start: with self-clear on,
        // its own match must not set the status again
        if (matched && !(line_start && st_r.ctl[`CTL_CLR_SEL]))
            sts_set[`ST_LINE] = 1'b1;
        if (fifo_underrun)
            sts_set[`ST_UNDERRUN] = 1'b1;

        // palette then data fetching
        case (st_r.pal)
            PAL_IDLE: begin
                if (frame_start && st_r.ctl[`CTL_ON]) begin
                    st_nxt.pal_cnt = '0;
                    if (palette_load_select == `LOAD_BOTH ||
                        palette_load_select == `LOAD_PALETTE)
                        st_nxt.pal = PAL_REQ;
                    else if (palette_load_select == `LOAD_DATA)
                        st_nxt.pal = PAL_DATA;
                end
            end
            PAL_REQ: begin
                st_nxt.req     = 1'b1;
                st_nxt.req_pal = 1'b1;
                if (st_r.req && link.fetch_ack) begin
                    st_nxt.req     = 1'b0;
                    st_nxt.pal_cnt = st_r.pal_cnt + 8'h1;
                    st_nxt.gap     = st_r.ctl[`CTL_SPACING_LO +: 8];
                    if (32'(st_r.pal_cnt) == PAL_WORDS - 1) begin
                        sts_set[`ST_LOADED] = 1'b1;
                        st_nxt.pal =
                            (palette_load_select == `LOAD_PALETTE) ?
                            PAL_IDLE : PAL_DATA;
                    end else if (st_r.ctl[`CTL_SPACING_LO +: 8] != 8'h0) begin
                        st_nxt.pal = PAL_GAP;
                    end
                end
            end
            PAL_GAP: begin
                st_nxt.gap = st_r.gap - 8'h1;
                if (st_r.gap <= 8'h1)
                    st_nxt.pal = PAL_REQ;
            end
            PAL_DATA: begin
                st_nxt.req_pal = 1'b0;
                if (st_r.req && link.fetch_ack)
                    st_nxt.req = 1'b0;
                if (line_start && st_r.active)
                    st_nxt.req = line_fetched(st_r.sub, st_nxt.line);
                if (!st_r.ctl[`CTL_ON] && frame_start)
                    st_nxt.pal = PAL_IDLE;
            end
            default: st_nxt.pal = PAL_IDLE;
        endcase
        // follows the line being entered, so it never overlaps its fetch
        st_nxt.dflt = (st_nxt.pal == PAL_DATA) &&
                      !line_fetched(st_r.sub, st_nxt.line);

        // line status may clear itself at the end of the line
        if (st_r.ctl[`CTL_CLR_SEL] && line_start)
            st_nxt.sts[`ST_LINE] = 1'b0;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `OFS_CONTROL:    st_nxt.ctl = {7'h0, reg_wdata[24:0]};
                `OFS_TIMING_A:   st_nxt.tim_a = reg_wdata;
                `OFS_TIMING_B:   st_nxt.tim_b = reg_wdata;
                `OFS_TIMING_C:   st_nxt.tim_c = reg_wdata;
                `OFS_STATUS:
                    st_nxt.sts = st_nxt.sts & reg_wdata[5:0];
                `OFS_SUBPANEL:   st_nxt.sub = reg_wdata;
                `OFS_LINE_MATCH: st_nxt.match = reg_wdata[LINE_W-1:0];
                default: ; // scan status is read-only
            endcase
        end
        st_nxt.sts = st_nxt.sts | sts_set; // set wins over clear

        // register reads, data one cycle later
        if (reg_rd) begin
            case (reg_addr)
                `OFS_CONTROL:    st_nxt.rdata = st_r.ctl | `CTL_RESV;
                `OFS_TIMING_A:   st_nxt.rdata = st_r.tim_a;
                `OFS_TIMING_B:   st_nxt.rdata = st_r.tim_b;
                `OFS_TIMING_C:   st_nxt.rdata = st_r.tim_c;
                `OFS_STATUS:     st_nxt.rdata = {26'h0, st_r.sts};
                `OFS_SUBPANEL:   st_nxt.rdata = st_r.sub;
                `OFS_LINE_MATCH: st_nxt.rdata = 32'(st_r.match);
                `OFS_SCAN: begin
                    st_nxt.rdata = 32'(st_r.line);
                    st_nxt.rdata[31] = st_r.active;
                    st_nxt.rdata[30] = st_r.dflt;
                    st_nxt.rdata[29] = st_r.pal != PAL_DATA &&
                                       st_r.pal != PAL_IDLE;
                    st_nxt.rdata[28] = matched;
                end
                default:         st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{ctl: `RST_WORD, tim_a: `RST_WORD, tim_b: `RST_WORD,
                      tim_c: `RST_WORD, sts: '0, sub: `RST_WORD,
                      match: '0, line: '0, active: 1'b0, pal: PAL_IDLE,
                      pal_cnt: '0, gap: '0, req: 1'b0, req_pal: 1'b0,
                      dflt: 1'b0, rdata: `RST_WORD};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs
    // source enables: sync error and underrun are never masked
    always_comb begin
        src_en               = 6'h30;
        src_en[`ST_DONE]     = st_r.ctl[`CTL_DONE_EN];
        src_en[`ST_VSYNC]    = st_r.ctl[`CTL_VSYNC_EN];
        src_en[`ST_LOADED]   = st_r.ctl[`CTL_LOAD_EN];
        src_en[`ST_LINE]     = st_r.ctl[`CTL_LINE_NIRQ];
    end

    assign link.irq_n        = ~|(st_r.sts & src_en);
    assign link.line_irq_n   = ~(st_r.sts[`ST_LINE] &
                                 st_r.ctl[`CTL_LINE_EN]);
    assign link.fetch_req     = st_r.req;
    assign link.fetch_palette = st_r.req_pal;
    assign link.default_fill  = st_r.dflt;
    assign reg_rdata           = st_r.rdata;
    assign use_default_pixel   = st_r.dflt;
    assign default_pixel_value = st_r.sub[15:0];
    assign controller_on       = st_r.ctl[`CTL_ON];
endmodule : lcd_status_irq_regs
`default_nettype wire

/* logic/lcd_dma_agent.sv */
// system side: dma channel answering fetches, line request routing,
// interrupt collection and dma clock gating
// assumes the controller holds fetch_req until fetch_ack
`include "lcd_status_irq_cfg.svh"
`default_nettype none
module lcd_dma_agent
    import lcd_status_irq_pkg::*;
#(
    parameter int CHANNELS = 16
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [31:0] buffer_words,
    input  wire logic [3:0]  dma_logical_channel,
    output logic             host_irq,
    output logic [CHANNELS-1:0] channel_req,
    output logic             dma_clk_en,
    output logic [15:0]      palette_acks,
    lcd_link_if.system       link
);
    initial begin
        if (CHANNELS < 1 || CHANNELS > 16)
            $error("lcd_dma_agent: unsupported channel count");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic                ack;
        logic [15:0]         pal_acks;
        logic [CHANNELS-1:0] chan;
        logic                irq;
        logic                clk_en;
        logic [31:0]         words;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ack      = link.fetch_req && !st_r.ack;
        if (link.fetch_req && !st_r.ack && link.fetch_palette)
            st_nxt.pal_acks = st_r.pal_acks + 16'h1;
        st_nxt.chan     = '0;
        // line request steered to the selected channel
        st_nxt.chan[dma_logical_channel] = !link.line_irq_n;
        st_nxt.irq      = !link.irq_n;
        st_nxt.clk_en   = !link.default_fill || link.fetch_req;
        st_nxt.words    = buffer_words;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{ack: 1'b0, pal_acks: '0, chan: '0, irq: 1'b0,
                      clk_en: 1'b1, words: `RST_WORD};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.fetch_ack = st_r.ack;
    assign link.buf_words = st_r.words;
    assign host_irq       = st_r.irq;
    assign channel_req    = st_r.chan;
    assign dma_clk_en     = st_r.clk_en;
    assign palette_acks   = st_r.pal_acks;
endmodule : lcd_dma_agent
`default_nettype wire

/* tb/lcd_link_assertions.sv */
// link checker: fetch handshake, fill quiet time, interrupt lines
// assumes the interface signals come in as plain inputs
`default_nettype none
module lcd_link_assertions (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        fetch_req,
    input wire logic        fetch_palette,
    input wire logic        fetch_ack,
    input wire logic        default_fill,
    input wire logic [31:0] buf_words,
    input wire logic        irq_n,
    input wire logic        line_irq_n
);
    // ========
    // single clock domain
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    property p_req_hold;
        fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_palette);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("fetch request dropped before ack");
    property p_ack_prompt;
        $rose(fetch_req) |=> fetch_ack;
    endproperty
    a_ack_prompt: assert property (p_ack_prompt)
        else $error("fetch ack late");
    property p_ack_with_req;
        fetch_ack |-> fetch_req && $past(fetch_req);
    endproperty
    a_ack_with_req: assert property (p_ack_with_req)
        else $error("fetch ack without request");
    property p_ack_pulse;
        fetch_ack |=> !fetch_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("fetch ack longer than one cycle");
    property p_req_gap;
        fetch_ack |=> !fetch_req;
    endproperty
    a_req_gap: assert property (p_req_gap)
        else $error("no request gap after ack");
    // the dma may stop its clocks here, so a request would be lost
    property p_fill_quiet;
        default_fill && !fetch_palette |-> !fetch_req;
    endproperty
    a_fill_quiet: assert property (p_fill_quiet)
        else $error("frame buffer fetch during default fill");
    property p_line_level;
        $fell(line_irq_n) |=> !line_irq_n [*2];
    endproperty
    a_line_level: assert property (p_line_level)
        else $error("line interrupt shorter than a level");
    property p_reset_idle;
        $rose(arst_n) |-> irq_n && line_irq_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("interrupt lines not idle high after reset");
endmodule : lcd_link_assertions
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench: panel controller facing its dma side
// assumes both ends meet in lcd_link_if on one 200 MHz clock
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 4;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        line_start = 1'b0;
    logic        frame_start = 1'b0;
    logic        fifo_underrun = 1'b0;
    // 20 x 10 pixels at 4 bpp in 16-bit words
    logic [31:0] buffer_words = 32'h32;
    logic [3:0]  dma_logical_channel = 4'hf;
    logic [31:0] reg_rdata;
    logic        use_default_pixel;
    logic [15:0] default_pixel_value;
    logic        controller_on;
    logic        host_irq;
    logic [15:0] channel_req;
    logic        dma_clk_en;
    logic [15:0] palette_acks;
    logic [15:0] acks = 16'h0;
    logic        req_q = 1'b0;
    int          gap = 255;
    int          min_gap = 255;
    int          data_n = 0;
    int          d0;
    int          bad_count = 0;
    int          comparisons = 0;
    lcd_link_if link ();
    lcd_status_irq_regs #(.LINE_W(10), .PAL_WORDS(P))
        lcd_status_irq_regs_inst (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_start(line_start),
        .frame_start(frame_start), .fifo_underrun(fifo_underrun),
        .use_default_pixel(use_default_pixel),
        .default_pixel_value(default_pixel_value),
        .controller_on(controller_on),
        .link(link.device));
    lcd_dma_agent #(.CHANNELS(16)) lcd_dma_agent_inst (
        .core_clk(core_clk), .arst_n(arst_n), .buffer_words(buffer_words),
        .dma_logical_channel(dma_logical_channel), .host_irq(host_irq),
        .channel_req(channel_req), .dma_clk_en(dma_clk_en),
        .palette_acks(palette_acks), .link(link.system));
    lcd_link_assertions lcd_link_assertions_inst (
        .core_clk(core_clk), .arst_n(arst_n), .fetch_req(link.fetch_req),
        .fetch_palette(link.fetch_palette), .fetch_ack(link.fetch_ack),
        .default_fill(link.default_fill), .buf_words(link.buf_words),
        .irq_n(link.irq_n), .line_irq_n(link.line_irq_n));
    always #2.5 core_clk = ~core_clk;
    // ========
    // palette request spacing and data fetch count
    always @(posedge core_clk) begin
        req_q <= link.fetch_req;
        if (link.fetch_ack) gap <= 0;
        else if (!link.fetch_req && gap < 255) gap <= gap + 1;
        if (link.fetch_req && !req_q) begin
            if (!link.fetch_palette) data_n <= data_n + 1;
            else if (gap < min_gap) min_gap <= gap;
        end
    end
    // ========
    // access tasks
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bit_check(input string what, input logic exp,
                             input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask : bit_check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string what, input logic [31:0] m = '1);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata & m);
    endtask : rdc
    task automatic pulse(input logic [2:0] fls);
        @(posedge core_clk);
        {frame_start, line_start, fifo_underrun} <= fls;
        @(posedge core_clk);
        {frame_start, line_start, fifo_underrun} <= 3'h0;
        #1;
    endtask : pulse
    task automatic lines(input int n);
        repeat (n) begin
            pulse(3'h2);
            repeat (6) @(posedge core_clk);
        end
        #1;
    endtask : lines
    task automatic wait_acks(input logic [15:0] n);
        int k;
        for (k = 0; k < 300 && palette_acks !== n; k++) @(posedge core_clk);
        if (k == 300) begin
            bad_count++;
            print_verdict();
        end
    endtask : wait_acks
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        print_verdict();
    end
    // ========
    // scenarios
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc(8'h00, 32'hfe00_0000, "control reset");
        for (int i = 1; i < 7; i++)
            rdc(8'(4 * i), 32'h0, "reset word");
        rdc(8'h20, 32'h0, "unmapped");
        wr(8'h04, 32'h13);
        wr(8'h08, 32'h9);
        wr(8'h0c, 32'h2);
        // line 0 must not match while the status scenarios run
        wr(8'h18, 32'h2);
        rdc(8'h04, 32'h13, "timing a");
        rdc(8'h08, 32'h9, "timing b");
        rdc(8'h0c, 32'h2, "timing c");
        rdc(8'h18, 32'h2, "line match");
        wr(8'h00, 32'h0030_0001);
        bit_check("controller on", 1'b1, controller_on);
        rdc(8'h00, 32'hfe30_0001, "control");
        pulse(3'h4);
        bit_check("irq_n buffer match", 1'b1, link.irq_n);
        rdc(8'h10, 32'h2, "status vsync");
        @(posedge core_clk) buffer_words <= 32'h31;
        pulse(3'h4);
        bit_check("irq_n sync error", 1'b0, link.irq_n);
        @(posedge core_clk) buffer_words <= 32'h32;
        pulse(3'h4);
        bit_check("host irq", 1'b1, host_irq);
        rdc(8'h10, 32'h12, "status sticky");
        wr(8'h10, 32'hffff_ffef);
        bit_check("irq_n cleared", 1'b1, link.irq_n);
        wr(8'h1c, 32'h0);
        rdc(8'h1c, 32'h8000_0000, "scan status", 32'hefff_ffff);
        pulse(3'h1);
        rdc(8'h10, 32'h22, "status underrun");
        bit_check("irq_n underrun", 1'b0, link.irq_n);
        wr(8'h10, 32'h0);
        pulse(3'h4);
        wr(8'h00, 32'h0030_0000);
        bit_check("controller off", 1'b0, controller_on);
        pulse(3'h4);
        rdc(8'h10, 32'h3, "status done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'h0030_0000 | (32'h2 << i) & 32'hc);
            bit_check("irq_n mask", i == 0, link.irq_n);
        end
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h0030_0461);
        pulse(3'h4);
        lines(1);
        bit_check("line irq early", 1'b1, link.line_irq_n);
        lines(1);
        bit_check("line irq", 1'b0, link.line_irq_n);
        bit_check("shared irq", 1'b0, link.irq_n);
        check("channel req", 32'h8000, {16'h0, channel_req});
        lines(1);
        bit_check("line irq end", 1'b1, link.line_irq_n);
        @(posedge core_clk) dma_logical_channel <= 4'h0;
        wr(8'h00, 32'h0030_0061);
        pulse(3'h4);
        lines(3);
        bit_check("line irq held", 1'b0, link.line_irq_n);
        check("channel req 0", 32'h1, {16'h0, channel_req});
        wr(8'h10, 32'hffff_fffb);
        bit_check("line irq cleared", 1'b1, link.line_irq_n);
        bit_check("shared irq cleared", 1'b1, link.irq_n);
        for (int m = 0; m < 4; m++) begin
            // load mode changes only with the controller off
            wr(8'h00, 32'h0);
            pulse(3'h4);
            wr(8'h10, 32'h0);
            wr(8'h00, 32'h0000_3001 | (32'(m) << 20));
            pulse(3'h4);
            acks = acks + ((m < 2) ? 16'(P) : 16'h0);
            wait_acks(acks);
            check("palette acks", {16'h0, acks}, {16'h0, palette_acks});
            repeat (8) @(posedge core_clk);
            rdc(8'h10, {28'h0, m < 2, 3'h0}, "loaded", 32'h8);
            d0 = data_n;
            lines(1);
            check("data fetch", {31'h0, !m[0]}, 32'(data_n - d0));
        end
        check("palette gap", 32'h1, {31'h0, min_gap >= 3});
        wr(8'h00, 32'h0020_0001);
        for (int t = 1; t >= 0; t--) begin
            wr(8'h14, {1'b1, t[0], 14'h2, 16'hbeef});
            pulse(3'h4);
            lines(1);
            bit_check("default early", !t[0], use_default_pixel);
            lines(2);
            bit_check("default late", t[0], use_default_pixel);
            bit_check("dma clock", !t[0], dma_clk_en);
        end
        check("pixel", 32'hbeef, {16'h0, default_pixel_value});
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
